// ---- design/spimp_top.sv ----
// SPI message port: shared-pin routing, byte stream shifter, outgoing FIFO,
// transmit-ready pin and port idle timeout.
// Assumes the host is the SPI controller and its clock is far slower than MCLK_IN.
`include "spimp_defines.svh"
`default_nettype none
module spimp_top
    import spimp_pkg::*;
#(
    parameter int     TX_DEPTH    = `SPIMP_TX_DEPTH,
    parameter int     EXT_LIMIT   = `SPIMP_EXT_LIMIT,
    parameter longint IDLE_CYCLES = `SPIMP_IDLE_CYCLES
) (
    // Clock and reset
    input  wire logic                          MCLK_IN,
    input  wire logic                          RST_IN,
    // Interface-select strap and shared pins
    input  wire logic                          IF_SEL_STRAP_IN,
    output var  logic                          PIN42_OUT,
    output var  logic                          PIN42_OE_OUT,
    input  wire logic                          PIN43_IN,
    input  wire logic                          PIN44_IN,
    output var  logic                          PIN44_OUT,
    output var  logic                          PIN44_OE_OUT,
    input  wire logic                          PIN45_IN,
    // First async port and I2C functions
    input  wire logic                          FIRST_ASYNC_PORT_TXD_IN,
    output var  logic                          FIRST_ASYNC_PORT_RXD_OUT,
    input  wire logic                          I2C_SDA_DRIVE_LOW_IN,
    output var  logic                          I2C_SDA_OUT,
    output var  logic                          I2C_SCL_OUT,
    input  wire logic                          I2C_ACTIVITY_IN,
    // Outgoing stream from software
    input  wire logic                          TX_VALID_IN,
    input  wire logic [7:0]                    TX_DATA_IN,
    output var  logic                          TX_READY_OUT,
    // Incoming message stream
    output var  logic                          RX_VALID_OUT,
    output var  logic [7:0]                    RX_DATA_OUT,
    input  wire logic                          RX_READY_IN,
    output var  logic                          RX_OVERRUN_OUT,
    // Pending pin config
    input  wire logic                          CFG_WRITE_IN,
    input  wire logic                          CFG_PIN_OK_IN,
    input  wire logic                          CFG_EN_IN,
    input  wire logic                          CFG_POL_IN,
    input  wire logic [$clog2(TX_DEPTH):0]     CFG_THRESH_IN,
    input  wire logic                          CFG_EXT_TIMEOUT_IN,
    output var  logic                          CFG_EN_OUT,
    output var  logic                          CFG_POL_OUT,
    output var  logic [$clog2(TX_DEPTH):0]     CFG_THRESH_OUT,
    // Status
    output var  logic                          TX_PENDING_PIN_OUT,
    output var  logic                          PORT_IDLE_OUT
);
    localparam int AW = $clog2(TX_DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(TX_DEPTH);
    localparam logic [CW-1:0] EXT_C   = CW'(EXT_LIMIT);
    localparam logic [31:0]   IDLE_C  = IDLE_CYCLES[31:0];

    if ((TX_DEPTH < 2) || ((1 << AW) != TX_DEPTH) || (EXT_LIMIT > TX_DEPTH) ||
        (IDLE_CYCLES < 1) || (IDLE_CYCLES > 64'h0000_0000_FFFF_FFFF))
    begin : g_bad_params
        $error("spimp_top: unsupported parameter values");
    end

    function automatic logic rose(input logic prev, input logic cur);
        return !prev && cur;
    endfunction : rose

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Order: strap, sclk, cs_n, mosi, pin43, pin44, pin45
    // Clock bit resets to its mode 0 idle level so no false edge follows reset
    logic [6:0] s1_q, s2_q;
    logic [1:0] s3_q;
    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            s1_q <= 7'h7D;
            s2_q <= 7'h7D;
            s3_q <= 2'h2;
        end
        else
        begin
            s1_q <= {PIN45_IN, PIN44_IN, PIN43_IN, PIN43_IN, PIN44_IN, PIN45_IN,
                     IF_SEL_STRAP_IN};
            s2_q <= s1_q;
            s3_q <= {s2_q[2], s2_q[1]};
        end
    end

    logic spi_sel;
    logic cs_n_now, cs_n_old, sclk_now, sclk_old, mosi_now;
    logic cs_fall, sclk_rise, sclk_fall;
    always_comb
    begin
        spi_sel   = (s2_q[0] == `SPIMP_STRAP_SPI);
        sclk_now  = s2_q[1];
        sclk_old  = s3_q[0];
        cs_n_now  = s2_q[2] | !spi_sel;
        cs_n_old  = s3_q[1] | !spi_sel;
        mosi_now  = s2_q[3];
        cs_fall   = rose(cs_n_now, cs_n_old);
        sclk_rise = rose(sclk_old, sclk_now) && !cs_n_now;
        sclk_fall = rose(sclk_now, sclk_old) && !cs_n_now;
    end

    // ==========================================================
    // Outgoing FIFO storage
    // ==========================================================
    logic [7:0]    tx_mem [TX_DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          tx_rdy_q;
    logic          idle_q, idle_d;
    logic          sw_push, sw_store;
    logic          pop;

    always_ff @(posedge MCLK_IN)
    begin
        if (sw_store)
        begin
            tx_mem[wr_q] <= TX_DATA_IN;
        end
    end

    // ==========================================================
    // Link shifter and parser
    // ==========================================================
    spimp_link_e st_q, st_d;
    logic [2:0]  bit_q, bit_d;
    spimp_byte_t rx_sh_q, rx_sh_d;
    spimp_byte_t tx_sh_q, tx_sh_d;
    logic        reload_q, reload_d;
    logic [5:0]  ffrun_q, ffrun_d;
    logic        susp_q, susp_d;
    logic        sdo_q, sdo_d;
    logic        ovr_q, ovr_d;
    logic        rx_push;
    spimp_byte_t rx_byte;
    logic        rx_in_ready;
    logic        load;

    always_comb
    begin
        st_d     = st_q;
        bit_d    = bit_q;
        rx_sh_d  = rx_sh_q;
        tx_sh_d  = tx_sh_q;
        reload_d = reload_q;
        ffrun_d  = ffrun_q;
        susp_d   = susp_q;
        rx_push  = 1'b0;
        rx_byte  = {rx_sh_q[6:0], mosi_now};
        load     = 1'b0;
        unique case (st_q)
            SPIMP_LS_IDLE:
            begin
                if (cs_fall)
                begin
                    load  = 1'b1;
                    bit_d = 3'h0;
                    st_d  = SPIMP_LS_XFER;
                end
            end
            SPIMP_LS_XFER:
            begin
                if (cs_n_now)
                begin
                    st_d     = SPIMP_LS_IDLE;
                    reload_d = 1'b0;
                end
                else if (sclk_rise)
                begin
                    rx_sh_d = rx_byte;
                    if (bit_q == `SPIMP_LAST_BIT)
                    begin
                        bit_d    = 3'h0;
                        reload_d = 1'b1;
                        if (rx_byte != `SPIMP_IDLE_BYTE)
                        begin
                            ffrun_d = 6'h0;
                            susp_d  = 1'b0;
                            rx_push = 1'b1;
                        end
                        else if (!susp_q)
                        begin
                            rx_push = 1'b1;
                            ffrun_d = ffrun_q + 6'h1;
                            susp_d  = (ffrun_d == `SPIMP_FF_RUN_LIMIT);
                        end
                    end
                    else
                    begin
                        bit_d = bit_q + 3'h1;
                    end
                end
                else if (sclk_fall)
                begin
                    if (reload_q)
                    begin
                        load     = 1'b1;
                        reload_d = 1'b0;
                    end
                    else
                    begin
                        tx_sh_d = {tx_sh_q[6:0], 1'b1};
                    end
                end
            end
        endcase
        pop = load && (cnt_q != '0);
        if (load)
        begin
            tx_sh_d = pop ? tx_mem[rd_q] : `SPIMP_IDLE_BYTE;
        end
        sdo_d = (st_d == SPIMP_LS_XFER) ? tx_sh_d[7] : 1'b1;
        ovr_d = rx_push && !rx_in_ready;
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            st_q     <= SPIMP_LS_IDLE;
            bit_q    <= 3'h0;
            rx_sh_q  <= 8'h00;
            tx_sh_q  <= `SPIMP_IDLE_BYTE;
            reload_q <= 1'b0;
            ffrun_q  <= 6'h0;
            susp_q   <= 1'b0;
            sdo_q    <= 1'b1;
            ovr_q    <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            bit_q    <= bit_d;
            rx_sh_q  <= rx_sh_d;
            tx_sh_q  <= tx_sh_d;
            reload_q <= reload_d;
            ffrun_q  <= ffrun_d;
            susp_q   <= susp_d;
            sdo_q    <= sdo_d;
            ovr_q    <= ovr_d;
        end
    end

    spimp_fifo2 #(
        .W (8)
    ) u_rx_buf (
        .clk_in        (MCLK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (rx_push),
        .in_ready_out  (rx_in_ready),
        .in_data_in    (rx_byte),
        .out_valid_out (RX_VALID_OUT),
        .out_ready_in  (RX_READY_IN),
        .out_data_out  (RX_DATA_OUT)
    );

    // ==========================================================
    // FIFO pointers, ready pin, idle timeout, pin mux
    // ==========================================================
    logic          en_q, en_d, pol_q, pol_d, ext_q, ext_d;
    logic [CW-1:0] thr_q, thr_d;
    logic          act_q, act_d;
    logic [31:0]   idle_cnt_q, idle_cnt_d;
    logic          activity;
    logic          p42_d, p42oe_d, p44oe_d, rxd_d, sda_d, scl_d;

    always_comb
    begin
        sw_push  = TX_VALID_IN && tx_rdy_q;
        sw_store = sw_push && !idle_q;
        wr_d     = sw_store ? wr_q + AW'(1) : wr_q;
        rd_d     = pop ? rd_q + AW'(1) : rd_q;
        cnt_d    = cnt_q + CW'(sw_store) - CW'(pop);
        en_d     = en_q;
        pol_d    = pol_q;
        thr_d    = thr_q;
        ext_d    = ext_q;
        if (CFG_WRITE_IN)
        begin
            ext_d = CFG_EXT_TIMEOUT_IN;
            en_d  = CFG_PIN_OK_IN & CFG_EN_IN;
            pol_d = CFG_PIN_OK_IN & CFG_POL_IN;
            thr_d = CFG_PIN_OK_IN ? CFG_THRESH_IN : '0;
        end
        act_d = en_q && (act_q ? (cnt_d != '0) : ((cnt_d >= thr_q) && (cnt_d != '0)));
        activity   = cs_fall || (!spi_sel && I2C_ACTIVITY_IN);
        idle_cnt_d = activity ? 32'h0000_0000 :
                     ((idle_cnt_q < IDLE_C) ? idle_cnt_q + 32'h0000_0001 : idle_cnt_q);
        idle_d = !activity && (idle_q || ((idle_cnt_q >= IDLE_C) &&
                 (!ext_q || (cnt_q >= EXT_C))));
        p42_d   = spi_sel ? sdo_q : FIRST_ASYNC_PORT_TXD_IN;
        p42oe_d = spi_sel ? !cs_n_now : 1'b1;
        p44oe_d = !spi_sel && I2C_SDA_DRIVE_LOW_IN;
        rxd_d   = spi_sel | s2_q[4];
        sda_d   = spi_sel | s2_q[5];
        scl_d   = spi_sel | s2_q[6];
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            tx_rdy_q   <= 1'b0;
            en_q       <= 1'b0;
            pol_q      <= 1'b0;
            thr_q      <= '0;
            ext_q      <= 1'b0;
            act_q      <= 1'b0;
            idle_cnt_q <= 32'h0000_0000;
            idle_q     <= 1'b0;
            PIN42_OUT  <= 1'b1;
            PIN42_OE_OUT <= 1'b0;
            PIN44_OE_OUT <= 1'b0;
            FIRST_ASYNC_PORT_RXD_OUT <= 1'b1;
            I2C_SDA_OUT <= 1'b1;
            I2C_SCL_OUT <= 1'b1;
            TX_PENDING_PIN_OUT <= 1'b1;
        end
        else
        begin
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            cnt_q      <= cnt_d;
            tx_rdy_q   <= (cnt_d != DEPTH_C);
            en_q       <= en_d;
            pol_q      <= pol_d;
            thr_q      <= thr_d;
            ext_q      <= ext_d;
            act_q      <= act_d;
            idle_cnt_q <= idle_cnt_d;
            idle_q     <= idle_d;
            PIN42_OUT  <= p42_d;
            PIN42_OE_OUT <= p42oe_d;
            PIN44_OE_OUT <= p44oe_d;
            FIRST_ASYNC_PORT_RXD_OUT <= rxd_d;
            I2C_SDA_OUT <= sda_d;
            I2C_SCL_OUT <= scl_d;
            TX_PENDING_PIN_OUT <= pol_d ? act_d : !act_d;
        end
    end

    // Shared-pin SDA is open drain: only ever drives low
    assign PIN44_OUT      = 1'b0;
    assign TX_READY_OUT   = tx_rdy_q;
    assign RX_OVERRUN_OUT = ovr_q;
    assign CFG_EN_OUT     = en_q;
    assign CFG_POL_OUT    = pol_q;
    assign CFG_THRESH_OUT = thr_q;
    assign PORT_IDLE_OUT  = idle_q;
endmodule : spimp_top
`default_nettype wire

// ---- include/spimp_defines.svh ----
// Constants of the SPI message port: offsets-free port, so only values and timing.
// Assumes a 200 MHz core clock; included by the top-level design file only.
`ifndef SPIMP_DEFINES_SVH
`define SPIMP_DEFINES_SVH

`define SPIMP_IDLE_BYTE     8'hFF
`define SPIMP_FF_RUN_LIMIT  6'h32
`define SPIMP_STRAP_SPI     1'b0
`define SPIMP_TX_DEPTH      4096
`define SPIMP_EXT_LIMIT     4096
`define SPIMP_LAST_BIT      3'h7
`define SPIMP_IDLE_TIME_MS  64'h0000_0000_0000_07D0
`define SPIMP_CLK_KHZ       64'h0000_0000_0003_0D40
`define SPIMP_IDLE_CYCLES   (`SPIMP_IDLE_TIME_MS * `SPIMP_CLK_KHZ)

`endif

// ---- include/spimp_pkg.sv ----
// Types shared by the SPI message port design files.
// Assumes the defines header is on the include path.
`default_nettype none
package spimp_pkg;
    typedef logic [7:0] spimp_byte_t;
    typedef enum logic
    {
        SPIMP_LS_IDLE = 1'b0,
        SPIMP_LS_XFER = 1'b1
    } spimp_link_e;
endpackage : spimp_pkg
`default_nettype wire

// ---- design/spimp_fifo2.sv ----
// Two-entry buffer with valid and ready on both sides; all outputs registered.
// Assumes one clock and an asynchronous active-high reset.
`default_nettype none
module spimp_fifo2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Filling side
    input  wire logic         in_valid_in,
    output var  logic         in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    // Draining side
    output var  logic         out_valid_out,
    input  wire logic         out_ready_in,
    output var  logic [W-1:0] out_data_out
);
    logic [1:0]   cnt_q, cnt_d;
    logic [W-1:0] head_q, head_d;
    logic [W-1:0] tail_q, tail_d;
    logic         push;
    logic         pop;

    always_comb
    begin
        push   = in_valid_in & in_ready_out;
        pop    = out_valid_out & out_ready_in;
        cnt_d  = cnt_q;
        head_d = head_q;
        tail_d = tail_q;
        if (push && pop)
        begin
            if (cnt_q == 2'h1)
            begin
                head_d = in_data_in;
            end
            else
            begin
                head_d = tail_q;
                tail_d = in_data_in;
            end
        end
        else if (pop)
        begin
            head_d = tail_q;
            cnt_d  = cnt_q - 2'h1;
        end
        else if (push)
        begin
            if (cnt_q == 2'h0)
            begin
                head_d = in_data_in;
            end
            else
            begin
                tail_d = in_data_in;
            end
            cnt_d = cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q         <= 2'h0;
            head_q        <= '0;
            tail_q        <= '0;
            out_valid_out <= 1'b0;
            in_ready_out  <= 1'b1;
        end
        else
        begin
            cnt_q         <= cnt_d;
            head_q        <= head_d;
            tail_q        <= tail_d;
            out_valid_out <= (cnt_d != 2'h0);
            in_ready_out  <= (cnt_d != 2'h2);
        end
    end

    assign out_data_out = head_q;
endmodule : spimp_fifo2
`default_nettype wire

// ---- bench/spimp_host.sv ----
// SPI controller model for the message port, clock mode 0, MSB first.
// Assumes one frame at a time; its clock stands still between frames.
`default_nettype none
module spimp_host
    import spimp_pkg::*;
(
    // Controller lines
    output var  logic sclk_out,
    output var  logic cs_n_out,
    output var  logic mosi_out,
    // Device output and its enable
    input  wire logic miso_in,
    input  wire logic miso_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b1;
    end
    // ==========================================
    // One framed transfer of whole bytes
    task automatic frame(input spimp_byte_t tx[$], output spimp_byte_t rx[$]);
        spimp_byte_t b;
        rx = {};
        cs_n_out = 1'b0;
        #48;
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                mosi_out = tx[i][k];
                #24;
                sclk_out = 1'b1;
                b[k] = miso_oe_in ? miso_in : 1'bx;
                #24;
                if (k > 0 || i + 1 < tx.size())
                    sclk_out = 1'b0;
            end
            rx.push_back(b);
        end
        // Release select with the clock high so no further byte is loaded
        cs_n_out = 1'b1;
        #24;
        sclk_out = 1'b0;
        mosi_out = ~mosi_out;
    endtask : frame
endmodule : spimp_host
`default_nettype wire

// ---- bench/spimp_top_chk.sv ----
// Checker for the SPI message port: pin routing, config, rx hold, idle timing.
// Assumes it is bound to spimp_top and sees only its ports.
`default_nettype none
module spimp_top_chk #(
    parameter longint IDLE_CYCLES = 200
) (
    // Clock and reset
    input wire logic       MCLK_IN,
    input wire logic       RST_IN,
    // Pins
    input wire logic       IF_SEL_STRAP_IN,
    input wire logic       PIN42_OUT,
    input wire logic       PIN42_OE_OUT,
    input wire logic       PIN44_IN,
    input wire logic       I2C_ACTIVITY_IN,
    // Streams, config and status
    input wire logic       RX_VALID_OUT,
    input wire logic [7:0] RX_DATA_OUT,
    input wire logic       RX_READY_IN,
    input wire logic       CFG_WRITE_IN,
    input wire logic       CFG_PIN_OK_IN,
    input wire logic       CFG_EN_IN,
    input wire logic       CFG_EXT_TIMEOUT_IN,
    input wire logic       CFG_EN_OUT,
    input wire logic       CFG_POL_OUT,
    input wire logic       TX_PENDING_PIN_OUT,
    input wire logic       PORT_IDLE_OUT
);
    // ==========================================
    // Cycles since the last port activity
    logic [31:0] quiet_q;
    logic [31:0] quiet_d;
    logic        ext_q;
    logic        ext_d;
    logic        cs_n_q;
    always_comb
    begin
        ext_d   = CFG_WRITE_IN ? CFG_EXT_TIMEOUT_IN : ext_q;
        quiet_d = quiet_q + {31'h0000_0000, ~&quiet_q};
        if ((cs_n_q && !PIN44_IN && !IF_SEL_STRAP_IN) || (I2C_ACTIVITY_IN && IF_SEL_STRAP_IN))
            quiet_d = 32'h0000_0000;
    end
    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            {quiet_q, ext_q, cs_n_q} <= {32'h0000_0000, 1'h0, 1'h1};
        else
            {quiet_q, ext_q, cs_n_q} <= {quiet_d, ext_d, PIN44_IN};
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    property p_uart_pin;
        IF_SEL_STRAP_IN [*5] |-> PIN42_OE_OUT;
    endproperty
    a_uart_pin: assert property (p_uart_pin) else $error("pin 42 undriven in async mode");
    property p_spi_idle;
        (PIN44_IN && !IF_SEL_STRAP_IN) [*5] |-> PIN42_OUT && !PIN42_OE_OUT;
    endproperty
    a_spi_idle: assert property (p_spi_idle) else $error("serial output not idle high");
    property p_cfg_load;
        CFG_WRITE_IN && CFG_PIN_OK_IN |=> CFG_EN_OUT == $past(CFG_EN_IN);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("enable not loaded");
    property p_cfg_drop;
        CFG_WRITE_IN && !CFG_PIN_OK_IN |=> !CFG_EN_OUT && !CFG_POL_OUT;
    endproperty
    a_cfg_drop: assert property (p_cfg_drop) else $error("bad pin config kept");
    property p_pin_off;
        (!CFG_EN_OUT && $stable(CFG_POL_OUT)) [*3] |-> TX_PENDING_PIN_OUT != CFG_POL_OUT;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled ready pin active");
    property p_rx_hold;
        RX_VALID_OUT && !RX_READY_IN |=> RX_VALID_OUT && $stable(RX_DATA_OUT);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost while stalled");
    property p_idle_early;
        $rose(PORT_IDLE_OUT) |-> quiet_q + 32'h0000_0004 >= IDLE_CYCLES;
    endproperty
    a_idle_early: assert property (p_idle_early) else $error("port idled too early");
    property p_idle_late;
        quiet_q >= IDLE_CYCLES + 8 && !ext_q && !$past(ext_q, 4) |-> PORT_IDLE_OUT;
    endproperty
    a_idle_late: assert property (p_idle_late) else $error("port not idled");
endmodule : spimp_top_chk
`default_nettype wire

// ---- bench/spimp_top_test.sv ----
// Self-checking bench for the SPI message port.
// Assumes the host model and checker are compiled before this file.
`default_nettype none
module spimp_top_test
    import spimp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK_IN, RST_IN, IF_SEL_STRAP_IN, PIN42_OUT, PIN42_OE_OUT, PIN43_IN;
    logic        PIN44_IN, PIN44_OUT, PIN44_OE_OUT, PIN45_IN, FIRST_ASYNC_PORT_TXD_IN;
    logic        FIRST_ASYNC_PORT_RXD_OUT, I2C_SDA_DRIVE_LOW_IN, I2C_SDA_OUT, I2C_SCL_OUT;
    logic        I2C_ACTIVITY_IN, TX_VALID_IN, TX_READY_OUT, RX_VALID_OUT, RX_READY_IN;
    logic        RX_OVERRUN_OUT, CFG_WRITE_IN, CFG_PIN_OK_IN, CFG_EN_IN, CFG_POL_IN;
    logic        CFG_EXT_TIMEOUT_IN, CFG_EN_OUT, CFG_POL_OUT, TX_PENDING_PIN_OUT, PORT_IDLE_OUT;
    logic [7:0]  TX_DATA_IN, RX_DATA_OUT;
    logic [4:0]  CFG_THRESH_IN, CFG_THRESH_OUT;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          n_ovr = 0;
    int          n_msg = 0;
    spimp_byte_t got[$], rdq[$], tq[$], eq[$];
    spimp_top #(.TX_DEPTH(16), .EXT_LIMIT(8), .IDLE_CYCLES(5000)) i_dut (.*);
    spimp_host i_host (.sclk_out(PIN45_IN), .cs_n_out(PIN44_IN), .mosi_out(PIN43_IN),
                       .miso_in(PIN42_OUT), .miso_oe_in(PIN42_OE_OUT));
    initial
    begin
        MCLK_IN = 1'b0;
        forever #2.5 MCLK_IN = ~MCLK_IN;
    end
    always @(posedge MCLK_IN)
    begin
        if (RX_VALID_OUT === 1'b1 && RX_READY_IN === 1'b1)
            got.push_back(RX_DATA_OUT);
        if (RX_OVERRUN_OUT === 1'b1)
            n_ovr++;
    end
    // ==========================================
    // Tasks
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK_IN);
    endtask : tick
    task automatic push(input spimp_byte_t q[$]);
        int n;
        foreach (q[i])
        begin
            TX_VALID_IN <= 1'b1;
            TX_DATA_IN  <= q[i];
            n = 0;
            do
            begin
                @(posedge MCLK_IN);
                n++;
            end while (TX_READY_OUT !== 1'b1 && n < 40);
            if (n >= 40)
            begin
                n_mismatch++;
                close_out();
            end
        end
        TX_VALID_IN <= 1'b0;
    endtask : push
    task automatic cfg(input logic ok, en, pol, ext, input logic [4:0] thr);
        {CFG_WRITE_IN, CFG_PIN_OK_IN, CFG_EN_IN} <= {1'b1, ok, en};
        {CFG_POL_IN, CFG_EXT_TIMEOUT_IN, CFG_THRESH_IN} <= {pol, ext, thr};
        @(posedge MCLK_IN);
        CFG_WRITE_IN <= 1'b0;
        tick(3);
    endtask : cfg
    // Levels of the strap and the async-port and I2C side inputs
    task automatic pins(input logic strap, sda_low, txd, act);
        IF_SEL_STRAP_IN         <= strap;
        I2C_SDA_DRIVE_LOW_IN    <= sda_low;
        FIRST_ASYNC_PORT_TXD_IN <= txd;
        I2C_ACTIVITY_IN         <= act;
    endtask : pins
    task automatic xfer(input spimp_byte_t tx[$], input spimp_byte_t ex[$]);
        i_host.frame(tx, rdq);
        tick(9);
        chk(rdq.size(), ex.size());
        foreach (ex[i])
            chk(rdq[i], ex[i]);
    endtask : xfer
    task automatic rxchk(input spimp_byte_t ex[$]);
        chk(got.size(), ex.size());
        foreach (ex[i])
            chk(got[i], ex[i]);
        got = {};
    endtask : rxchk
    initial
    begin
        #200000;
        n_mismatch++;
        close_out();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        RST_IN = 1'b1;
        {IF_SEL_STRAP_IN, FIRST_ASYNC_PORT_TXD_IN, I2C_SDA_DRIVE_LOW_IN, I2C_ACTIVITY_IN} = '0;
        {TX_VALID_IN, TX_DATA_IN, CFG_WRITE_IN, CFG_PIN_OK_IN, CFG_EN_IN} = '0;
        {CFG_POL_IN, CFG_THRESH_IN, CFG_EXT_TIMEOUT_IN} = '0;
        RX_READY_IN = 1'b1;
        tick(5);
        RST_IN <= 1'b0;
        chk(TX_PENDING_PIN_OUT, 1'b1);
        chk(CFG_EN_OUT, 1'b0);
        tick(4);
        push({8'hA5, 8'h3C, 8'h81});
        xfer({8'h12, 8'h34, 8'h56, 8'h78}, {8'hA5, 8'h3C, 8'h81, 8'hFF});
        rxchk({8'h12, 8'h34, 8'h56, 8'h78});
        cfg(1'b1, 1'b1, 1'b1, 1'b0, 5'h02);
        chk(CFG_THRESH_OUT, 5'h02);
        chk(TX_PENDING_PIN_OUT, 1'b0);
        push({8'h11});
        tick(2);
        chk(TX_PENDING_PIN_OUT, 1'b0);
        push({8'h22});
        tick(2);
        chk(TX_PENDING_PIN_OUT, 1'b1);
        xfer({8'hFF}, {8'h11});
        chk(TX_PENDING_PIN_OUT, 1'b1);
        xfer({8'hFF}, {8'h22});
        chk(TX_PENDING_PIN_OUT, 1'b0);
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 5'h00);
        push({8'h33});
        tick(2);
        chk(TX_PENDING_PIN_OUT, 1'b0);
        cfg(1'b0, 1'b1, 1'b1, 1'b0, 5'h03);
        chk(CFG_THRESH_OUT, 5'h00);
        chk(TX_PENDING_PIN_OUT, 1'b1);
        rxchk({8'hFF, 8'hFF});
        tq = {8'h01};
        repeat (52) tq.push_back(8'hFF);
        tq.push_back(8'h02);
        eq = {8'h33};
        repeat (53) eq.push_back(8'hFF);
        xfer(tq, eq);
        foreach (rdq[i])
            n_msg += int'(rdq[i] != 8'hFF);
        chk(n_msg, 1);
        eq = tq[0:50];
        eq.push_back(8'h02);
        rxchk(eq);
        RX_READY_IN <= 1'b0;
        xfer({8'h41, 8'h42, 8'h43}, {8'hFF, 8'hFF, 8'hFF});
        chk(n_ovr, 1);
        chk(RX_DATA_OUT, 8'h41);
        RX_READY_IN <= 1'b1;
        tick(4);
        rxchk({8'h41, 8'h42});
        tq = {};
        for (int i = 0; i < 16; i++)
            tq.push_back(8'(i));
        push(tq);
        tick(2);
        chk(TX_READY_OUT, 1'b0);
        xfer(tq, tq);
        rxchk(tq);
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 5'h00);
        tick(5100);
        chk(PORT_IDLE_OUT, 1'b0);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
        chk(PORT_IDLE_OUT, 1'b1);
        push({8'h55});
        xfer({8'h0F}, {8'hFF});
        chk(PORT_IDLE_OUT, 1'b0);
        rxchk({8'h0F});
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        tick(6);
        pins(1'b1, 1'b1, 1'b0, 1'b1);
        tick(1);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        tick(4);
        chk(PIN42_OUT, 1'b0);
        chk(PIN42_OE_OUT, 1'b1);
        chk({PIN44_OE_OUT, PIN44_OUT}, 2'b10);
        chk({I2C_SDA_OUT, I2C_SCL_OUT}, 2'b10);
        chk(FIRST_ASYNC_PORT_RXD_OUT, PIN43_IN);
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        tick(2);
        chk(PIN42_OUT, 1'b1);
        close_out();
    end
endmodule : spimp_top_test
bind spimp_top spimp_top_chk #(.IDLE_CYCLES(IDLE_CYCLES)) i_chk (.*);
`default_nettype wire
